// file: hw/xm_pkg.sv
// package: constants, register map and state codes of the external memory interface
package xm_pkg;
    // ****************************************
    // register indices (byte address = index * 4)
    // ****************************************
    localparam logic [9:0] XM_IDX_MAIN = 10'h035;
    localparam logic [9:0] XM_IDX_CTLB = 10'h06c;
    localparam logic [9:0] XM_IDX_CTLA = 10'h06d;
    localparam logic [9:0] XM_IDX_PORT = 10'h070;
    localparam logic [9:0] XM_IDX_CFG = 10'h071;
    // ****************************************
    // field positions
    // ****************************************
    localparam int XM_MAIN_EN_BIT = 7;
    localparam int XM_MAIN_UWL_BIT = 6;
    localparam int XM_CTLA_SL_LSB = 4;
    localparam int XM_CTLA_LWH_BIT = 3;
    localparam int XM_CTLA_LWL_BIT = 2;
    localparam int XM_CTLA_UWH_BIT = 1;
    localparam int XM_CTLB_KEEP_BIT = 7;
    localparam int XM_CFG_COMPAT_BIT = 0;
    localparam int XM_CFG_CVAL_LSB = 1;
    localparam int XM_CFG_CDIR_LSB = 4;
    localparam logic [7:0] XM_CTLA_MASK = 8'h7e;
    localparam logic [7:0] XM_CTLB_MASK = 8'h87;
    localparam logic [6:0] XM_CFG_MASK = 7'h7f;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] XM_MAIN_RST = 8'h00;
    localparam logic [7:0] XM_CTLA_RST = 8'h00;
    localparam logic [7:0] XM_CTLB_RST = 8'h00;
    localparam logic [31:0] XM_PORT_RST = 32'h0000_0000;
    localparam logic [6:0] XM_CFG_RST = 7'h00;
    // ****************************************
    // address map and timing
    // ****************************************
    localparam logic [15:0] XM_EXT_BASE = 16'h1100;
    localparam int XM_SECTOR_SHIFT = 13;
    localparam logic [1:0] XM_WAIT_NONE = 2'b00;
    localparam logic [1:0] XM_WAIT_GAP = 2'b11;
    typedef enum logic [4:0] {
        XM_IDLE = 5'b00001,
        XM_ADDR = 5'b00010,
        XM_STRB = 5'b00100,
        XM_END = 5'b01000,
        XM_GAP = 5'b10000
    } xm_state_e;
endpackage : xm_pkg

// file: hw/xm_sel_if.sv
// interface: address and wait settings to the sector selector and its answer
interface xm_sel_if;
    logic [15:0] addr;
    logic [2:0] limit;
    logic [1:0] upper_wait;
    logic [1:0] lower_wait;
    logic compat;
    logic is_ext;
    logic [1:0] wait_code;
    modport req (output addr, limit, upper_wait, lower_wait, compat,
                 input is_ext, wait_code);
    modport sel (input addr, limit, upper_wait, lower_wait, compat,
                 output is_ext, wait_code);
endinterface : xm_sel_if

// file: hw/xm_wait_sel.sv
// sector decode: internal or external, and the wait code of the sector hit
module xm_wait_sel (
    xm_sel_if.sel s
);
    import xm_pkg::*;
    logic [15:0] bound;
    logic upper;
    always_comb begin
        bound = {s.limit, 13'h0000};
        s.is_ext = (s.addr >= XM_EXT_BASE); // RL19
        upper = (s.limit == 3'd0) || (s.addr >= bound); // RL10 RL11
        if (s.compat) begin
            // legacy: one sector, single wait bit only
            s.wait_code = {1'b0, s.upper_wait[0]}; // RL9
        end else if (upper) begin
            s.wait_code = s.upper_wait; // RL12
        end else begin
            s.wait_code = s.lower_wait; // RL13
        end
    end
endmodule : xm_wait_sel

// file: hw/xm_top.sv
// top: register slave, access sequencer and pin control of the memory interface
// Operation
// RL1 - enable bit hands pins to interface
// RL2 - interface overrides port direction settings
// RL3 - disabled: pins follow port value, direction
// RL4 - pull-ups follow port value bits
// RL5 - keeper holds last level when released
// RL6 - four wait settings, two sectors
// RL7 - trailing latch pulse only if next accesses
// RL8 - memory must not rely on clock phase
// RL9 - legacy mode: one wait bit, one cycle
// RL10 - limit zero: whole range is upper sector
// RL11 - limit code times 0x2000 starts upper sector
// RL12 - upper wait bits time upper sector
// RL13 - lower wait bits time lower sector
// RL14 - wait codes: 0, 1, 2, 2 plus gap
// RL15 - reserved bits read zero, write zero
// RL16 - address valid at latch fall, latch low
// RL17 - internal access: no read/write strobes
// RL18 - keeper independent of interface enable
// RL19 - per access internal/external and sector wait
//
// Implementation choice: the AHB-Lite interface to the registers.
module xm_top (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // core data access
    input wire logic acc_valid_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic acc_write_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic acc_next_mem_i,
    output logic acc_busy_o,
    output logic acc_done_o,
    output logic [7:0] acc_rdata_o,
    // multiplexed address/data pins
    input wire logic [7:0] ad_i,
    output logic [7:0] ad_o,
    output logic [7:0] ad_oen_o,
    output logic [7:0] ad_pullup_o,
    output logic ad_keep_en_o,
    output logic [7:0] ad_keep_lvl_o,
    // high address pins
    output logic [7:0] hi_o,
    output logic [7:0] hi_oen_o,
    // strobes
    output logic ale_o,
    output logic ale_oen_o,
    output logic rd_n_o,
    output logic rd_oen_o,
    output logic wr_n_o,
    output logic wr_oen_o
);
    import xm_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] main_q;
    logic [7:0] ctla_q;
    logic [7:0] ctlb_q;
    logic [31:0] port_q;
    logic [6:0] cfg_q;
    logic en;
    logic compat;
    logic wr_pend_q;
    logic [9:0] widx_q;
    logic addr_ok;
    logic [9:0] ridx;
    logic [31:0] rd_val;
    logic [31:0] wr_val;

    assign en = main_q[XM_MAIN_EN_BIT];
    assign compat = cfg_q[XM_CFG_COMPAT_BIT];
    assign addr_ok = hsel_i && htrans_i[1] && hready_i;
    assign ridx = haddr_i[11:2];

    function automatic logic [31:0] reg_view(input logic [9:0] idx, input logic [31:0] w);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx == XM_IDX_MAIN) begin
            v = {24'h000000, w[7:0]};
        end else if (idx == XM_IDX_CTLA) begin
            v = {24'h000000, w[7:0] & XM_CTLA_MASK}; // RL15
        end else if (idx == XM_IDX_CTLB) begin
            v = {24'h000000, w[7:0] & XM_CTLB_MASK};
        end else if (idx == XM_IDX_PORT) begin
            v = w;
        end else if (idx == XM_IDX_CFG) begin
            v = {25'h0000000, w[6:0] & XM_CFG_MASK};
        end
        return v;
    endfunction : reg_view

    always_comb begin
        if (ridx == XM_IDX_MAIN) begin
            rd_val = {24'h000000, main_q};
        end else if (ridx == XM_IDX_CTLA) begin
            rd_val = {24'h000000, ctla_q};
        end else if (ridx == XM_IDX_CTLB) begin
            rd_val = {24'h000000, ctlb_q};
        end else if (ridx == XM_IDX_PORT) begin
            rd_val = port_q;
        end else if (ridx == XM_IDX_CFG) begin
            rd_val = {25'h0000000, cfg_q};
        end else begin
            rd_val = 32'h0000_0000;
        end
        if (haddr_i[31:12] != 20'h00000) begin
            rd_val = 32'h0000_0000;
        end
        // write still in its data phase wins, so back-to-back read sees it
        if (wr_pend_q && widx_q == ridx) begin
            rd_val = reg_view(ridx, hwdata_i);
        end
        wr_val = reg_view(widx_q, hwdata_i);
    end

    // ****************************************
    // ahb-lite slave
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_pend_q <= 1'b0;
            widx_q <= 10'h000;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else if (ce_i) begin
            wr_pend_q <= addr_ok && hwrite_i && (haddr_i[31:12] == 20'h00000);
            widx_q <= ridx;
            if (addr_ok && !hwrite_i) begin
                hrdata_o <= rd_val;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            main_q <= XM_MAIN_RST;
            ctla_q <= XM_CTLA_RST;
            ctlb_q <= XM_CTLB_RST;
            port_q <= XM_PORT_RST;
            cfg_q <= XM_CFG_RST;
        end else if (ce_i && wr_pend_q) begin
            if (widx_q == XM_IDX_MAIN) begin
                main_q <= wr_val[7:0];
            end else if (widx_q == XM_IDX_CTLA) begin
                ctla_q <= wr_val[7:0];
            end else if (widx_q == XM_IDX_CTLB) begin
                ctlb_q <= wr_val[7:0];
            end else if (widx_q == XM_IDX_PORT) begin
                port_q <= wr_val;
            end else if (widx_q == XM_IDX_CFG) begin
                cfg_q <= wr_val[6:0];
            end
        end
    end

    // ****************************************
    // sector selection
    // ****************************************
    xm_sel_if sel ();
    assign sel.addr = acc_addr_i;
    assign sel.limit = ctla_q[XM_CTLA_SL_LSB +: 3];
    assign sel.upper_wait = {ctla_q[XM_CTLA_UWH_BIT], main_q[XM_MAIN_UWL_BIT]};
    assign sel.lower_wait = {ctla_q[XM_CTLA_LWH_BIT], ctla_q[XM_CTLA_LWL_BIT]};
    assign sel.compat = compat;

    xm_wait_sel u_sel (
        .s(sel)
    );

    // ****************************************
    // access sequencer
    // ****************************************
    xm_state_e state_q;
    xm_state_e state_d;
    logic [15:0] addr_q;
    logic [15:0] addr_d;
    logic [7:0] wdata_q;
    logic write_q;
    logic ext_q;
    logic nxt_q;
    logic [1:0] wcode_q;
    logic [1:0] cnt_q;
    logic take;

    assign take = (state_q == XM_IDLE) && acc_valid_i;
    assign addr_d = take ? acc_addr_i : addr_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            XM_IDLE: begin
                // disabled: nothing mapped outside, finish without pin activity
                if (acc_valid_i) begin
                    state_d = en ? XM_ADDR : XM_END;
                end
            end
            XM_ADDR: begin
                state_d = XM_STRB;
            end
            XM_STRB: begin
                if (cnt_q == 2'd0) begin
                    state_d = XM_END;
                end
            end
            XM_END: begin
                if (en && ext_q && !compat && wcode_q == XM_WAIT_GAP) begin
                    state_d = XM_GAP; // RL14
                end else begin
                    state_d = XM_IDLE;
                end
            end
            XM_GAP: begin
                state_d = XM_IDLE;
            end
            default: begin
                state_d = XM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= XM_IDLE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            write_q <= 1'b0;
            ext_q <= 1'b0;
            nxt_q <= 1'b0;
            wcode_q <= XM_WAIT_NONE;
        end else if (ce_i && take) begin
            addr_q <= acc_addr_i;
            wdata_q <= acc_wdata_i;
            write_q <= acc_write_i;
            ext_q <= sel.is_ext; // RL19
            nxt_q <= acc_next_mem_i;
            // internal accesses run at zero wait
            wcode_q <= sel.is_ext ? sel.wait_code : XM_WAIT_NONE; // RL6 RL19
        end
    end

    // strobe lasts two cycles plus the wait cycles of the code
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_q <= 2'd0;
        end else if (ce_i) begin
            if (state_q == XM_ADDR) begin
                cnt_q <= (wcode_q == XM_WAIT_NONE) ? 2'd1 :
                         (wcode_q == 2'b01) ? 2'd2 : 2'd3; // RL14 RL9
            end else if (state_q == XM_STRB && cnt_q != 2'd0) begin
                cnt_q <= cnt_q - 2'd1;
            end
        end
    end

    // ****************************************
    // read data, handshake
    // ****************************************
    logic [7:0] ad_s1;
    logic [7:0] ad_s2;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ad_s1 <= 8'h00;
            ad_s2 <= 8'h00;
        end else if (ce_i) begin
            ad_s1 <= ad_i;
            ad_s2 <= ad_s1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_rdata_o <= 8'h00;
            acc_done_o <= 1'b0;
            acc_busy_o <= 1'b0;
        end else if (ce_i) begin
            acc_done_o <= (state_q == XM_END);
            acc_busy_o <= (state_d != XM_IDLE);
            if (state_q == XM_END && !write_q) begin
                // synced bus shows the pins of the last strobe cycles
                acc_rdata_o <= (en && ext_q) ? ad_s2 : 8'h00;
            end
        end
    end

    // ****************************************
    // pins
    // ****************************************
    logic strobe_d;
    assign strobe_d = (state_d == XM_STRB) && ext_q && !take; // RL17

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ad_o <= 8'h00;
            ad_oen_o <= 8'hff;
            hi_o <= 8'h00;
            hi_oen_o <= 8'hff;
        end else if (ce_i) begin
            if (en) begin
                hi_o <= addr_d[15:8]; // RL1
                hi_oen_o <= 8'h00; // RL2
                if (state_d == XM_ADDR) begin
                    ad_o <= addr_d[7:0]; // RL16
                    ad_oen_o <= 8'h00;
                end else if ((state_d == XM_STRB || state_d == XM_END) && write_q) begin
                    ad_o <= wdata_q;
                    ad_oen_o <= 8'h00;
                end else begin
                    ad_oen_o <= 8'hff;
                end
            end else begin
                ad_o <= port_q[7:0]; // RL3
                ad_oen_o <= ~port_q[15:8];
                hi_o <= port_q[23:16];
                hi_oen_o <= ~port_q[31:24];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ale_o <= 1'b0;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            ale_oen_o <= 1'b1;
            rd_oen_o <= 1'b1;
            wr_oen_o <= 1'b1;
        end else if (ce_i) begin
            if (en) begin
                ale_oen_o <= 1'b0; // RL1
                rd_oen_o <= 1'b0;
                wr_oen_o <= 1'b0;
                // trailing pulse opens the next address early
                ale_o <= (state_d == XM_ADDR) ||
                         (state_d == XM_END && state_q != XM_IDLE && nxt_q); // RL7 RL16
                rd_n_o <= !(strobe_d && !write_q); // RL17
                wr_n_o <= !(strobe_d && write_q);
            end else begin
                ale_o <= cfg_q[XM_CFG_CVAL_LSB]; // RL3
                rd_n_o <= cfg_q[XM_CFG_CVAL_LSB + 1];
                wr_n_o <= cfg_q[XM_CFG_CVAL_LSB + 2];
                ale_oen_o <= !cfg_q[XM_CFG_CDIR_LSB];
                rd_oen_o <= !cfg_q[XM_CFG_CDIR_LSB + 1];
                wr_oen_o <= !cfg_q[XM_CFG_CDIR_LSB + 2];
            end
        end
    end

    // keeper: legacy mode has none; follows its own bit only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ad_keep_en_o <= 1'b0;
            ad_keep_lvl_o <= 8'h00;
            ad_pullup_o <= 8'h00;
        end else if (ce_i) begin
            ad_keep_en_o <= ctlb_q[XM_CTLB_KEEP_BIT] && !compat; // RL18 RL5
            ad_keep_lvl_o <= (ad_oen_o == 8'h00) ? ad_o : ad_s2; // RL5
            ad_pullup_o <= port_q[7:0] & (en ? 8'hff : ~port_q[15:8]); // RL4
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    logic strb_on;
    assign strb_on = !rd_n_o || !wr_n_o;

    property p_en_drive;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        en |=> (hi_oen_o == 8'h00) && !ale_oen_o && !rd_oen_o;
    endproperty
    a_en_drive: assert property (p_en_drive) else $error("pins not given to interface"); // RL1 RL2

    property p_dis_port;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        !en |=> (hi_oen_o == ~$past(port_q[31:24])) && (hi_o == $past(port_q[23:16]));
    endproperty
    a_dis_port: assert property (p_dis_port) else $error("disabled pins not on port"); // RL3

    property p_pullup;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        ##1 ad_pullup_o == ($past(port_q[7:0]) & ($past(en) ? 8'hff : ~$past(port_q[15:8])));
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up mismatch"); // RL4

    property p_keep;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        ##1 ad_keep_en_o == ($past(ctlb_q[XM_CTLB_KEEP_BIT]) && !$past(compat));
    endproperty
    a_keep: assert property (p_keep) else $error("keeper enable wrong"); // RL18 RL5

    sequence s_ext_addr(logic [1:0] c);
        state_q == XM_ADDR && en && ext_q && !compat && wcode_q == c;
    endsequence

    property p_wait0;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        s_ext_addr(2'b00) |=> strb_on [*2] ##1 !strb_on;
    endproperty
    a_wait0: assert property (p_wait0) else $error("zero wait strobe not 2"); // RL14

    property p_wait1;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        s_ext_addr(2'b01) |=> strb_on [*3] ##1 !strb_on;
    endproperty
    a_wait1: assert property (p_wait1) else $error("one wait strobe not 3"); // RL14

    property p_wait3;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        s_ext_addr(2'b11) |=> strb_on [*4] ##1 (!strb_on && state_q == XM_END) ##1
            (state_q == XM_GAP && !ale_o);
    endproperty
    a_wait3: assert property (p_wait3) else $error("gap wait sequence wrong"); // RL14

    property p_internal;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        (state_q == XM_STRB && !ext_q) |-> rd_n_o && wr_n_o;
    endproperty
    a_internal: assert property (p_internal) else $error("strobe on internal access"); // RL17

    property p_ale_tail;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        (state_q == XM_STRB && state_d == XM_END && en) |=> ale_o == nxt_q;
    endproperty
    a_ale_tail: assert property (p_ale_tail) else $error("trailing latch pulse wrong"); // RL7

    property p_ale_addr;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        (state_q == XM_ADDR && $past(en)) |-> ale_o && ad_oen_o == 8'h00 &&
            ad_o == addr_q[7:0] ##1 !ale_o;
    endproperty
    a_ale_addr: assert property (p_ale_addr) else $error("address not valid at latch"); // RL16

    property p_sector;
        @(posedge clk_i) disable iff (reset_i)
        (!compat && sel.is_ext) |-> sel.wait_code ==
            ((sel.limit == 3'd0 || acc_addr_i >= {sel.limit, 13'h0000}) ?
             sel.upper_wait : sel.lower_wait);
    endproperty
    a_sector: assert property (p_sector) else $error("sector wait wrong"); // RL10 RL11 RL12 RL13

    property p_compat;
        @(posedge clk_i) disable iff (reset_i)
        compat |-> sel.wait_code == {1'b0, main_q[XM_MAIN_UWL_BIT]};
    endproperty
    a_compat: assert property (p_compat) else $error("legacy wait wrong"); // RL9

    property p_resv;
        @(posedge clk_i) disable iff (reset_i || !ce_i)
        (addr_ok && !hwrite_i && ridx == XM_IDX_CTLA) |=> !hrdata_o[7] && !hrdata_o[0];
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero"); // RL15

    c_gap: cover property (@(posedge clk_i) state_q == XM_GAP);
    c_tail: cover property (@(posedge clk_i) state_q == XM_END && ale_o);
    c_read: cover property (@(posedge clk_i) acc_done_o && !write_q && ext_q);
endmodule : xm_top

// file: dv/xm_sram_model.sv
// external sram behind an address latch, driven by pin levels only
module xm_sram_model (
    // clock only paces the noise on a released bus
    input wire logic clk_i,
    // pins from the interface
    input wire logic [7:0] ad_out_i,
    input wire logic [7:0] ad_oen_i,
    input wire logic [7:0] hi_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    // resolved level of the multiplexed lines
    output logic [7:0] ad_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] lat_q;
    logic [7:0] open_q;
    logic [7:0] fill_q;
    // no clock phase is relied on: latch and store follow strobe edges
    // ale falls on the edge that turns the bus, so close on a settled copy
    always @(posedge ale_i) #10 open_q <= ad_o;
    always @(negedge ale_i) lat_q <= open_q;
    always @(posedge wr_n_i) mem[{hi_i, lat_q}] <= ad_o;
    // released bus never repeats its last value
    always @(posedge clk_i) fill_q <= ~ad_o;
    always_comb begin
        if (ad_oen_i == 8'h00) ad_o = ad_out_i;
        else if (!rd_n_i) ad_o = mem[{hi_i, lat_q}];
        else ad_o = fill_q;
    end
endmodule : xm_sram_model

// file: dv/testbench.sv
// testbench: registers, sector wait timing and memory traffic of the interface
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import xm_pkg::*;
    `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
    logic clk_i, reset_i, hwrite_i, hreadyout_o, hresp_o;
    logic ce_i = 1'b1;
    logic hsel_i = 1'b1;
    logic [2:0] hsize_i = 3'b010;
    wire hready_i = hreadyout_o;
    logic [1:0] htrans_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd_q;
    logic acc_valid_i, acc_write_i, acc_next_mem_i, acc_busy_o, acc_done_o;
    logic [15:0] acc_addr_i;
    logic [7:0] acc_wdata_i, acc_rdata_o, ad_i, ad_o, ad_oen_o, ad_pullup_o, ad_keep_lvl_o;
    logic [7:0] hi_o, hi_oen_o;
    logic ad_keep_en_o, ale_o, ale_oen_o, rd_n_o, rd_oen_o, wr_n_o, wr_oen_o;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 18562;
    xm_top u_dut (.*);
    xm_sram_model u_mem (.clk_i(clk_i), .ad_out_i(ad_o), .ad_oen_i(ad_oen_o), .hi_i(hi_o),
        .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .ad_o(ad_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ****************************************
    // expectations
    // ****************************************
    function automatic int ncyc(input logic [1:0] c);
        return (c == 2'b00) ? 5 : (c == 2'b01) ? 6 : 7;
    endfunction : ncyc
    function automatic logic [1:0] wcode(input logic [15:0] a, input logic [7:0] ca,
                                         input logic u0);
        if (ca[6:4] == 3'd0 || a >= {ca[6:4], 13'h0}) return {ca[1], u0};
        return ca[3:2];
    endfunction : wcode
    // ****************************************
    // drivers
    // ****************************************
    task automatic ahb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        htrans_i <= 2'b10;
        haddr_i <= {20'h0, idx, 2'b00};
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd_q = hrdata_o;
    endtask : ahb
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic nx,
                       input int ecyc, input int eale, input int estr);
        int cyc, nale, nstr;
        logic seen;
        @(posedge clk_i);
        acc_valid_i <= 1'b1;
        acc_addr_i <= a;
        acc_write_i <= w;
        acc_wdata_i <= d;
        acc_next_mem_i <= nx;
        @(posedge clk_i);
        acc_valid_i <= 1'b0;
        cyc = 0;
        nale = 0;
        nstr = 0;
        seen = 1'b0;
        do begin
            @(negedge clk_i);
            cyc++;
            if (ale_o === 1'b1 && !seen) begin
                `CHK({hi_o, ad_o, ad_oen_o}, {a, 8'h00})
                seen = 1'b1;
            end
            if (cyc == 2 && eale > 0) `CHK(ad_keep_lvl_o, a[7:0])
            nale += (ale_o === 1'b1);
            nstr += (rd_n_o === 1'b0 || wr_n_o === 1'b0);
        end while (acc_done_o !== 1'b1 && cyc < 40);
        `CHK(cyc, ecyc)
        `CHK(nale, eale)
        `CHK(nstr, estr)
        while (acc_busy_o === 1'b1) @(negedge clk_i);
    endtask : acc
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    // hang guard, far beyond the several hundred cycles the run needs
    initial begin
        #2_000_000;
        error_cnt++;
        finish_test();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        logic [15:0] a;
        logic [7:0] wv, ca, d;
        logic [1:0] c;
        logic nx, u0;
        reset_i = 1'b1;
        htrans_i = 2'b00;
        haddr_i = 32'h0;
        hwrite_i = 1'b0;
        hwdata_i = 32'h0;
        acc_valid_i = 1'b0;
        acc_addr_i = 16'h0;
        acc_write_i = 1'b0;
        acc_wdata_i = 8'h00;
        acc_next_mem_i = 1'b0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        ahb(1'b0, XM_IDX_CTLA, 32'h0);
        `CHK(rd_q, 32'h0000_0000)
        ahb(1'b0, 10'h3ff, 32'h0);
        `CHK({rd_q, hresp_o}, 33'h0)
        $display("register test done");
        // rd and wr port values high so a disabled bus shows no strobe
        ahb(1'b1, XM_IDX_CFG, 32'h0000_000c);
        ahb(1'b1, XM_IDX_PORT, 32'h003c_0fa5);
        ahb(1'b1, XM_IDX_CTLB, 32'h0000_0080);
        repeat (2) @(negedge clk_i);
        `CHK({ad_oen_o, ad_o, ale_o, rd_n_o, wr_n_o, ale_oen_o, rd_oen_o, wr_oen_o}, 22'h3c295f)
        `CHK(ad_pullup_o, 8'ha0)
        `CHK(ad_keep_en_o, 1'b1)
        acc(1'b0, 16'h9000, 8'h00, 1'b0, 2, 0, 0);
        ahb(1'b1, XM_IDX_MAIN, 32'h0000_0080);
        repeat (2) @(negedge clk_i);
        `CHK({ad_pullup_o, hi_oen_o, ale_oen_o, rd_oen_o, wr_oen_o}, 19'h52800)
        acc(1'b0, 16'h0800, 8'h00, 1'b1, 5, 2, 0);
        `CHK(acc_rdata_o, 8'h00)
        $display("pin test done");
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            // reserved bits 7 and 0 are written as zero
            wv = {1'b0, 3'(i), r[3:1], 1'b0};
            ca = wv & 8'h7e;
            u0 = r[8];
            ahb(1'b1, XM_IDX_MAIN, {24'h0, 1'b1, u0, 6'h0});
            ahb(1'b1, XM_IDX_CTLA, {24'h0, wv});
            ahb(1'b0, XM_IDX_CTLA, 32'h0);
            `CHK(rd_q, {24'h0, ca})
            r = $random(seed);
            a = (i < 8) ? {ca[6:4], 13'h0} - 16'(i % 2) : r[15:0];
            if (a < XM_EXT_BASE) a = a + XM_EXT_BASE;
            d = r[23:16];
            nx = r[24];
            c = wcode(a, ca, u0);
            acc(1'b1, a, d, nx, ncyc(c), 1 + nx, ncyc(c) - 3);
            acc(1'b0, a, 8'h00, !nx, ncyc(c), 2 - nx, ncyc(c) - 3);
            `CHK(acc_rdata_o, d)
        end
        $display("sector test done");
        ahb(1'b1, XM_IDX_CFG, 32'h0000_000d);
        ahb(1'b1, XM_IDX_MAIN, 32'h0000_00c0);
        acc(1'b1, 16'h2000, 8'h5a, 1'b0, 6, 1, 3);
        $display("legacy test done");
        finish_test();
    end
endmodule : testbench
